// [pkg/ext_irq_pkg.sv]
// constants and types for the external interrupt and wake logic
package ext_irq_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_ENABLE   = 8'h00;
  localparam logic [7:0] ADDR_SPECIAL  = 8'h04;
  localparam logic [7:0] ADDR_PENDING  = 8'h08;
  localparam logic [7:0] ADDR_MODE     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // ==========================================================
  // reset values
  localparam logic [3:0] ENABLE_RESET  = 4'h0;
  localparam logic [3:0] SPECIAL_RESET = 4'h0;
  localparam logic [3:0] PENDING_RESET = 4'h0;

  // ==========================================================
  // mode register write codes and status field positions
  localparam logic [1:0] MODE_CMD_IDLE      = 2'h1;
  localparam logic [1:0] MODE_CMD_POWERDOWN = 2'h2;
  localparam int         STATUS_NMI_BIT     = 4;
  localparam int         STATUS_RESUME_BIT  = 5;

  // ==========================================================
  // arbitration: index reported for the nonmaskable request and the one reported when nothing is requested
  localparam logic [2:0] NMI_INDEX  = 3'h4;
  localparam logic [2:0] NONE_INDEX = 3'h7;

  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_IDLE      = 2'b01,
    MODE_POWERDOWN = 2'b10
  } power_mode_t;

endpackage : ext_irq_pkg

// [design/ext_irq_wake.sv]
// external interrupt edge detection, nmi request and power-mode wake logic
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - in normal mode a rising edge on a line pin sets that line's pending bit.
// - each line pin is sampled once per state time, while the half-rate clock output is high.
// - in powerdown a special-function line held high across one whole state time returns the device to normal.
// - after powerdown wake an enabled line goes pending for service, else resume is signalled.
// - in idle any enabled pending source, the nmi request or a core source wakes the device.
// - in normal mode a rising edge on the nmi pin raises the nonmaskable request.
// - the nonmaskable request wins arbitration over every line request.
// - the clock output runs at half the internal rate with equal high and low halves.
module ext_irq_wake
  import ext_irq_pkg::*;
#(
  parameter int LINES = 4
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [LINES-1:0]  extIrqPins,
  input  wire logic              nmiPin,
  input  wire logic              coreIrqActive,
  input  wire logic              nmiAck,
  input  wire logic [LINES-1:0]  extAck,
  input  wire logic [7:0]        address,
  input  wire logic [31:0]       writeData,
  input  wire logic              writeStrobe,
  input  wire logic              readStrobe,
  output logic [31:0]            readData,
  output logic [LINES-1:0]       pendingOut,
  output logic                   nmiRequest,
  output logic                   irqActive,
  output logic [2:0]             irqIndex,
  output logic [1:0]             modeOut,
  output logic                   resumeNextPulse,
  output logic                   serviceWakePulse,
  output logic                   halfRateClockOutput
);

  // ==========================================================
  // state
  logic [LINES-1:0] syncA_reg;
  logic [LINES-1:0] syncB_reg;
  logic [LINES-1:0] sample_reg;
  logic             nmiSyncA_reg;
  logic             nmiSyncB_reg;
  logic             nmiSample_reg;
  logic [LINES-1:0] enable_reg;
  logic [LINES-1:0] special_reg;
  logic [LINES-1:0] pending_reg;
  logic [LINES-1:0] pending_next;
  logic             nmiReq_reg;
  logic             halfRate_reg;
  logic             resume_reg;
  logic             serviceWake_reg;
  logic             resumeFlag_reg;
  logic             irqActive_reg;
  logic [2:0]       irqIndex_reg;
  logic [31:0]      readData_reg;
  power_mode_t      mode_reg;
  power_mode_t      mode_next;

  // ==========================================================
  // clock output divider, doubles as the phase-2 sample enable
  always_ff @(posedge clock) begin
    if (rst) begin
      halfRate_reg <= 1'b0;
    end else begin
      halfRate_reg <= ~halfRate_reg;
    end
  end

  // sample on the last cycle of the high half, once per state time
  wire phase2En = halfRate_reg;

  // ==========================================================
  // synchronisers; the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      syncA_reg    <= '0;
      syncB_reg    <= '0;
      nmiSyncA_reg <= 1'b0;
      nmiSyncB_reg <= 1'b0;
    end else begin
      syncA_reg    <= extIrqPins;
      syncB_reg    <= syncA_reg;
      nmiSyncA_reg <= nmiPin;
      nmiSyncB_reg <= nmiSyncA_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sample_reg    <= '0;
      nmiSample_reg <= 1'b0;
    end else if (phase2En) begin
      sample_reg    <= syncB_reg;
      nmiSample_reg <= nmiSyncB_reg;
    end
  end

  // edge: this phase-2 sample high, the previous one low; a pulse at the enable only
  wire [LINES-1:0] riseVec = {LINES{phase2En}} & syncB_reg & ~sample_reg;
  wire             nmiRise = phase2En & nmiSyncB_reg & ~nmiSample_reg;
  // high at two consecutive samples means held for a full state time
  wire [LINES-1:0] heldVec = {LINES{phase2En}} & syncB_reg & sample_reg;

  // ==========================================================
  // register decode
  wire wrEnable  = writeStrobe && (address == ADDR_ENABLE);
  wire wrSpecial = writeStrobe && (address == ADDR_SPECIAL);
  wire wrPending = writeStrobe && (address == ADDR_PENDING);
  wire wrMode    = writeStrobe && (address == ADDR_MODE);

  wire inNormal    = (mode_reg == MODE_NORMAL);
  wire inIdle      = (mode_reg == MODE_IDLE);
  wire inPowerdown = (mode_reg == MODE_POWERDOWN);

  // only special-function lines may wake from powerdown, enabled or not
  wire [LINES-1:0] pdWakeVec = heldVec & special_reg;
  wire             pdWake    = inPowerdown && (|pdWakeVec);
  wire             pdService = |(pdWakeVec & enable_reg);
  wire             idleWake  = inIdle &&
                               ((|(pending_reg & enable_reg)) || nmiReq_reg || coreIrqActive);

  // edges also count in idle so an enabled line can end it
  wire [LINES-1:0] edgeSet = (inNormal || inIdle) ? riseVec : '0;
  wire [LINES-1:0] wakeSet = pdWake ? (pdWakeVec & enable_reg) : '0;
  wire [LINES-1:0] clrVec  = (wrPending ? writeData[LINES-1:0] : '0) | extAck;

  // set beats clear, so an edge in the clearing cycle is kept
  always_comb begin
    pending_next = (pending_reg & ~clrVec) | edgeSet | wakeSet;
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_NORMAL: begin
        if (wrMode && writeData[1:0] == MODE_CMD_IDLE) begin
          mode_next = MODE_IDLE;
        end else if (wrMode && writeData[1:0] == MODE_CMD_POWERDOWN) begin
          mode_next = MODE_POWERDOWN;
        end
      end
      MODE_IDLE: begin
        if (idleWake) begin
          mode_next = MODE_NORMAL;
        end
      end
      MODE_POWERDOWN: begin
        if (pdWake) begin
          mode_next = MODE_NORMAL;
        end
      end
      default: begin
        mode_next = MODE_NORMAL;
      end
    endcase
  end

  // ==========================================================
  // control registers and request flags
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_reg  <= ENABLE_RESET;
      special_reg <= SPECIAL_RESET;
      pending_reg <= PENDING_RESET;
      mode_reg    <= MODE_NORMAL;
    end else begin
      if (wrEnable) begin
        enable_reg <= writeData[LINES-1:0];
      end
      if (wrSpecial) begin
        special_reg <= writeData[LINES-1:0];
      end
      pending_reg <= pending_next;
      mode_reg    <= mode_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nmiReq_reg <= 1'b0;
    end else if (nmiRise && !inPowerdown) begin
      nmiReq_reg <= 1'b1;
    end else if (nmiAck) begin
      nmiReq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resume_reg      <= 1'b0;
      serviceWake_reg <= 1'b0;
      resumeFlag_reg  <= 1'b0;
    end else begin
      resume_reg      <= pdWake && !pdService;
      serviceWake_reg <= pdWake && pdService;
      if (pdWake) begin
        resumeFlag_reg <= !pdService;
      end
    end
  end

  // ==========================================================
  // arbitration: nmi first, then the lowest numbered enabled line
  logic [2:0] winIndex;
  always_comb begin
    winIndex = NONE_INDEX;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (pending_reg[i] && enable_reg[i]) begin
        winIndex = 3'(i);
      end
    end
    if (nmiReq_reg) begin
      winIndex = NMI_INDEX;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irqIndex_reg  <= NONE_INDEX;
      irqActive_reg <= 1'b0;
    end else begin
      irqIndex_reg  <= winIndex;
      irqActive_reg <= (winIndex != NONE_INDEX) && inNormal;
    end
  end

  // ==========================================================
  // read port; data stands in the cycle after the strobe, zero when unmapped
  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    case (address)
      ADDR_ENABLE:  readMux[LINES-1:0] = enable_reg;
      ADDR_SPECIAL: readMux[LINES-1:0] = special_reg;
      ADDR_PENDING: readMux[LINES-1:0] = pending_reg;
      ADDR_MODE:    readMux[1:0]       = mode_reg;
      ADDR_STATUS: begin
        readMux[LINES-1:0]         = sample_reg;
        readMux[STATUS_NMI_BIT]    = nmiReq_reg;
        readMux[STATUS_RESUME_BIT] = resumeFlag_reg;
      end
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readData_reg <= 32'h0000_0000;
    end else begin
      readData_reg <= readStrobe ? readMux : 32'h0000_0000;
    end
  end

  assign readData            = readData_reg;
  assign pendingOut          = pending_reg;
  assign nmiRequest          = nmiReq_reg;
  assign irqActive           = irqActive_reg;
  assign irqIndex            = irqIndex_reg;
  assign modeOut             = mode_reg;
  assign resumeNextPulse     = resume_reg;
  assign serviceWakePulse    = serviceWake_reg;
  assign halfRateClockOutput = halfRate_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence pdHeldWake_s;
    inPowerdown && (|pdWakeVec);
  endsequence

  sequence backNormal_s;
    mode_reg == MODE_NORMAL;
  endsequence

  pend_set_a: assert property (inNormal && |riseVec |=> (pending_reg & $past(riseVec)) == $past(riseVec))
    else $error("edge did not set pending");
  sample_phase_a: assert property ($changed(sample_reg) |-> $past(halfRate_reg))
    else $error("sample taken outside phase 2");
  clock_half_a: assert property (!rst ##1 !rst |-> halfRate_reg != $past(halfRate_reg))
    else $error("clock output did not toggle");
  pd_wake_a: assert property (pdHeldWake_s |=> backNormal_s)
    else $error("no wake from powerdown");
  pd_nowake_a: assert property (inPowerdown && !(|pdWakeVec) |=> mode_reg == MODE_POWERDOWN)
    else $error("wake from unconfigured line");
  resume_next_a: assert property (pdHeldWake_s ##0 !pdService |=> resume_reg && !serviceWake_reg)
    else $error("resume not signalled");
  service_wake_a: assert property (pdHeldWake_s ##0 pdService |=> serviceWake_reg && |pending_reg)
    else $error("service wake lost");
  idle_wake_a: assert property (inIdle && nmiReq_reg |=> backNormal_s)
    else $error("no wake from idle");
  nmi_raise_a: assert property (inNormal && nmiRise |=> nmiReq_reg)
    else $error("nmi edge missed");
  nmi_first_a: assert property ($past(nmiReq_reg) |-> irqIndex_reg == NMI_INDEX)
    else $error("nmi lost arbitration");
  edge_once_a: assert property (|riseVec |=> !(|riseVec) ##1
                                !(|(riseVec & $past(riseVec, 2))))
    else $error("edge flagged twice");

endmodule : ext_irq_wake

`default_nettype wire

// [verification/irq_source_model.sv]
// partner model: outside sources driving the line pins and the nmi pin
`timescale 1ns/1ns
`default_nettype none
module irq_source_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [4:0] fire,
  input  wire logic [2:0] holdLen,
  output logic      [3:0] extIrqPins,
  output logic            nmiPin
);
  // ======================================
  // high-time counters, index 4 is nmi
  logic [2:0] holdCount_reg [5] = '{default: 3'h0};
  always_ff @(posedge clock) begin
    for (int i = 0; i < 5; i++) begin
      if (rst) begin
        holdCount_reg[i] <= 3'h0;
      end else if (fire[i]) begin
        holdCount_reg[i] <= holdLen;
      end else if (holdCount_reg[i] != 3'h0) begin
        holdCount_reg[i] <= holdCount_reg[i] - 3'h1;
      end
    end
  end
  // bench keeps holdLen at 4 or more, above one state time of 2 cycles
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      extIrqPins[i] = holdCount_reg[i] != 3'h0;
    end
    nmiPin = holdCount_reg[4] != 3'h0;
  end
endmodule : irq_source_model
`default_nettype wire

// [verification/ext_irq_wake_tb_top.sv]
// self-checking bench for the external interrupt and wake logic
`timescale 1ns/1ns
`default_nettype none
module ext_irq_wake_tb_top;
  import ext_irq_pkg::*;
  // ======================================
  // stimulus and observed signals
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  extIrqPins, pendingOut;
  logic        nmiPin, nmiRequest, irqActive, resumeNextPulse, serviceWakePulse;
  logic        halfRateClockOutput;
  logic        coreIrqActive = 1'b0;
  logic        nmiAck = 1'b0;
  logic [3:0]  extAck = 4'h0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writeData = 32'h0;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic [31:0] readData, d, en;
  logic [2:0]  irqIndex, holdLen = 3'h4;
  logic [1:0]  modeOut;
  logic [4:0]  fire = 5'h0;
  logic [31:0] seed = 32'ha95016dc;
  logic        lastHalf, armed = 1'b0;
  logic [7:0]  regAddr [4] = '{ADDR_ENABLE, ADDR_SPECIAL, ADDR_PENDING, 8'h14};
  logic [3:0]  regInit [4] = '{ENABLE_RESET, SPECIAL_RESET, PENDING_RESET, 4'h0};
  int          n_fail = 0, checked = 0, cycles = 0, nSvc = 0, nRes = 0, expPend = 0, expIdx = 0;

  ext_irq_wake #(.LINES(4)) ext_irq_wake_i (.clock(clock), .rst(rst),
    .extIrqPins(extIrqPins), .nmiPin(nmiPin), .coreIrqActive(coreIrqActive),
    .nmiAck(nmiAck), .extAck(extAck), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .pendingOut(pendingOut), .nmiRequest(nmiRequest), .irqActive(irqActive),
    .irqIndex(irqIndex), .modeOut(modeOut), .resumeNextPulse(resumeNextPulse),
    .serviceWakePulse(serviceWakePulse), .halfRateClockOutput(halfRateClockOutput));
  irq_source_model irq_source_model_i (.clock(clock), .rst(rst), .fire(fire),
    .holdLen(holdLen), .extIrqPins(extIrqPins), .nmiPin(nmiPin));

  initial begin
    forever #5 clock = ~clock;
  end

  // ======================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic chkState(input logic [1:0] m);
    check(modeOut, m);
    check(pendingOut, expPend);
  endtask : chkState
  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    writeData <= v;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask : rd
  // pulse of zero sources doubles as a settle wait
  task automatic pulse(input logic [4:0] f);
    @(posedge clock);
    fire <= f;
    holdLen <= 3'h4 + 3'(xs() % 32'h4);
    @(posedge clock);
    fire <= 5'h0;
    repeat (14) @(posedge clock);
    #1;
  endtask : pulse

  // ======================================
  // free-running monitors and hang guard; falling edge, where outputs have settled
  always @(negedge clock) begin
    cycles++;
    nSvc += int'(serviceWakePulse === 1'b1);
    nRes += int'(resumeNextPulse === 1'b1);
    if (rst) begin
      armed = 1'b0;
    end else begin
      if (armed) check(halfRateClockOutput, !lastHalf);
      armed = 1'b1;
    end
    lastHalf = halfRateClockOutput;
    if (cycles == 4000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(regAddr[i]);
      check(d, regInit[i]);
    end
    en = xs() & 32'hf;
    wr(ADDR_ENABLE, en);
    rd(ADDR_ENABLE);
    check(d, en);
    for (int i = 0; i < 4; i++) begin
      pulse(5'(1 << i));
      expPend |= 1 << i;
      check(pendingOut, expPend);
    end
    expIdx = NONE_INDEX;
    for (int i = 3; i >= 0; i--) begin
      if (en[i]) expIdx = i;
    end
    check(irqIndex, expIdx);
    check(irqActive, en[3:0] != 4'h0);
    pulse(5'h10);
    check(nmiRequest, 32'h1);
    check(irqIndex, NMI_INDEX);
    check(irqActive, 32'h1);
    @(posedge clock);
    nmiAck <= 1'b1;
    extAck <= 4'h1;
    @(posedge clock);
    nmiAck <= 1'b0;
    extAck <= 4'h0;
    pulse(5'h0);
    expPend = 32'he;
    check(nmiRequest, 32'h0);
    chkState(2'h0);
    wr(ADDR_SPECIAL, 32'h3);
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_PENDING, 32'hf);
    expPend = 0;
    // line 2 not special, line 1 special but disabled, line 0 special and enabled
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_MODE, MODE_CMD_POWERDOWN);
      pulse(5'(4 >> k));
      expPend = int'(k == 2);
      chkState(k == 0 ? 2'h2 : 2'h0);
      check(nRes, k > 0);
      check(nSvc, k == 2);
    end
    wr(ADDR_PENDING, 32'hf);
    expPend = 8;
    wr(ADDR_MODE, MODE_CMD_IDLE);
    pulse(5'h8);
    chkState(2'h1);
    rd(ADDR_MODE);
    check(d, 32'h1);
    @(posedge clock);
    coreIrqActive <= 1'b1;
    @(posedge clock);
    coreIrqActive <= 1'b0;
    pulse(5'h0);
    chkState(2'h0);
    wr(ADDR_MODE, MODE_CMD_IDLE);
    pulse(5'h1);
    expPend = 9;
    chkState(2'h0);
    // idle left only by the nmi request: nothing enabled may stay pending
    wr(ADDR_PENDING, 32'hf);
    expPend = 0;
    wr(ADDR_MODE, MODE_CMD_IDLE);
    pulse(5'h10);
    chkState(2'h0);
    check(nmiRequest, 32'h1);
    rd(ADDR_STATUS);
    check(d, 1 << STATUS_NMI_BIT);
    test_done();
  end
endmodule : ext_irq_wake_tb_top
`default_nettype wire
